// ---- rtl/grf_pkg.sv ----
// Purpose: Shared constants, types and helpers for the register file block.
// Assumes: One core clock; all inputs but the asynchronous reset synchronous to it.
// Notes: Enum codes follow declaration order; ports carry these types.

package grf_pkg;

	// ----------------------------------------------------------------
	// Sizes and reset values
	// ----------------------------------------------------------------
	localparam int GRF_NREG = 16;
	localparam int GRF_XLEN = 64;
	localparam int GRF_SELW = 4;
	localparam int GRF_SEGW = 16;
	localparam int GRF_NSEG = 6;
	localparam int GRF_LANES = 8;
	localparam int GRF_ADDED_FIRST = 8;
	localparam logic [63:0] GRF_GPR_RST = 64'h0;
	localparam logic [15:0] GRF_SEG_RST = 16'h0;
	localparam logic [63:0] GRF_BASE_RST = 64'h0;
	localparam logic [63:0] GRF_IP_RST = 64'h0;
	// Selector field: bits above the table bit form the index
	localparam int GRF_SEL_TI_BIT = 2;
	// Read data appear this many edges after the request
	localparam int GRF_READ_LAT = 2;
	// Byte lane enables per operand size
	localparam logic [7:0] GRF_BE_B0 = 8'h01;
	localparam logic [7:0] GRF_BE_B1 = 8'h02;
	localparam logic [7:0] GRF_BE_W = 8'h03;
	localparam logic [7:0] GRF_BE_D = 8'h0f;
	localparam logic [7:0] GRF_BE_Q = 8'hff;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GRF_MODE_64, GRF_MODE_COMPAT, GRF_MODE_LEGACY
	} grf_mode_t;
	typedef enum logic [1:0] {
		GRF_SZ8, GRF_SZ16, GRF_SZ32, GRF_SZ64
	} grf_size_t;
	typedef enum logic [2:0] {
		GRF_SEG_CODE, GRF_SEG_STACK, GRF_SEG_FIRST_DATA,
		GRF_SEG_EXTRA_DATA, GRF_SEG_THIRD_DATA, GRF_SEG_FOURTH_DATA
	} grf_seg_t;
	typedef enum logic {GRF_LD_EXPLICIT, GRF_LD_TRANSFER} grf_load_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Returns {high_byte, register} for a byte selector
	function automatic logic [4:0] grf_byte_map(input logic [3:0] sel,
		input logic pfx);
		if (!pfx && sel[3:2] == 2'b01) begin
			grf_byte_map = {1'b1, 2'b00, sel[1:0]};
		end else begin
			grf_byte_map = {1'b0, sel};
		end
	endfunction : grf_byte_map

	// Wide size and added registers need the extension prefix
	function automatic logic grf_op_legal(input logic [3:0] sel,
		input grf_size_t size, input logic pfx);
		grf_op_legal = pfx || !(size == GRF_SZ64 || sel[3]);
	endfunction : grf_op_legal

endpackage : grf_pkg

// ---- rtl/grf_gpr_if.sv ----
// Purpose: Carrier between the control logic and the register storage.
// Assumes: Single clock domain.
// Notes: One write port with lane enables, two registered read ports.

`timescale 1ns/100ps
`default_nettype none

interface grf_gpr_if;
	logic we;
	logic [3:0] wsel;
	logic [7:0] wbe;
	logic wclr_hi;
	logic [63:0] wdata;
	logic clr_added;
	logic [3:0] ra_sel;
	logic [3:0] rb_sel;
	logic [63:0] ra_data;
	logic [63:0] rb_data;

	modport ctl (output we, wsel, wbe, wclr_hi, wdata, clr_added,
		ra_sel, rb_sel, input ra_data, rb_data);
	modport mem (input we, wsel, wbe, wclr_hi, wdata, clr_added,
		ra_sel, rb_sel, output ra_data, rb_data);
endinterface : grf_gpr_if

`default_nettype wire

// ---- rtl/grf_gpr_mem.sv ----
// Purpose: Sixteen 64-bit integer registers with byte lane writes.
// Assumes: Writer supplies lane enables and upper-half clear.
// Notes: Reads are registered and see the value before a same-edge write.

`timescale 1ns/100ps
`default_nettype none

module grf_gpr_mem (
	input wire logic clk, // Core clock
	input wire logic arst_n, // Async reset, active low
	grf_gpr_if.mem bus // Storage port
);
	import grf_pkg::*;

	logic [63:0] mem_q [GRF_NREG];
	logic [63:0] mem_d [GRF_NREG];
	logic [63:0] ra_q;
	logic [63:0] rb_q;

	// Lane merge, upper clear and bulk clear of the added registers
	always_comb begin
		mem_d = mem_q;
		if (bus.clr_added) begin
			for (int i = GRF_ADDED_FIRST; i < GRF_NREG; i++) begin
				mem_d[i] = GRF_GPR_RST;
			end
		end
		if (bus.we) begin
			for (int b = 0; b < GRF_LANES; b++) begin
				if (bus.wbe[b]) begin
					mem_d[bus.wsel][8*b +: 8] = bus.wdata[8*b +: 8];
				end
			end
			if (bus.wclr_hi) begin
				mem_d[bus.wsel][63:32] = 32'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < GRF_NREG; i++) begin
				mem_q[i] <= GRF_GPR_RST;
			end
			ra_q <= GRF_GPR_RST;
			rb_q <= GRF_GPR_RST;
		end else begin
			mem_q <= mem_d;
			ra_q <= mem_q[bus.ra_sel];
			rb_q <= mem_q[bus.rb_sel];
		end
	end

	assign bus.ra_data = ra_q;
	assign bus.rb_data = rb_q;
endmodule : grf_gpr_mem

`default_nettype wire

// ---- rtl/grf_seg_file.sv ----
// Purpose: Six segment selectors with their loaded bases.
// Assumes: Descriptor base arrives with the load.
// Notes: Refused loads leave every register unchanged.

`timescale 1ns/100ps
`default_nettype none

module grf_seg_file (
	input wire logic clk, // Core clock
	input wire logic arst_n, // Async reset, active low
	input wire logic ld_en, // Load request
	input wire grf_pkg::grf_seg_t ld_seg, // Target segment
	input wire grf_pkg::grf_load_t ld_kind, // Explicit or transfer
	input wire logic [15:0] ld_value, // New selector
	input wire logic [63:0] ld_base, // Descriptor base
	output logic ld_bad, // Load refused
	output logic [15:0] sel_o [grf_pkg::GRF_NSEG], // Selectors
	output logic [63:0] base_o [grf_pkg::GRF_NSEG] // Stored bases
);
	import grf_pkg::*;

	logic [15:0] sel_q [GRF_NSEG];
	logic [15:0] sel_d [GRF_NSEG];
	logic [63:0] base_q [GRF_NSEG];
	logic [63:0] base_d [GRF_NSEG];
	logic null_sel;

	// Legacy checks run in every mode so compat code can reuse the value
	always_comb begin
		null_sel = ld_value[15:GRF_SEL_TI_BIT] == 14'h0;
		ld_bad = 1'b0;
		if (ld_seg == GRF_SEG_CODE && ld_kind == GRF_LD_EXPLICIT) begin
			ld_bad = 1'b1;
		end else if (ld_seg == GRF_SEG_STACK && null_sel) begin
			ld_bad = 1'b1;
		end
		sel_d = sel_q;
		base_d = base_q;
		if (ld_en && !ld_bad) begin
			sel_d[ld_seg] = ld_value;
			base_d[ld_seg] = ld_base;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < GRF_NSEG; i++) begin
				sel_q[i] <= GRF_SEG_RST;
				base_q[i] <= GRF_BASE_RST;
			end
		end else begin
			sel_q <= sel_d;
			base_q <= base_d;
		end
	end

	assign sel_o = sel_q;
	assign base_o = base_q;
endmodule : grf_seg_file

`default_nettype wire

// ---- rtl/grf_top.sv ----
// Purpose: Integer and segment register file for the 64-bit core mode.
// Assumes: One prefix flag per instruction, shared by all its operands.
// Notes: Reads answer two edges after the request; writes take one edge.
//
// How it works
// - Sixteen registers; default operand width 32 bits.
// - Every register has 8/16/32/64-bit views.
// - Wide size, added registers need extension prefix.
// - Added registers survive compat round trip.
// - Legacy round trip may discard added registers.
// - No prefix: selectors 4-7 pick high bytes.
// - No mixing legacy high bytes with new bytes.
// - Prefix: selectors 4-7 pick pointer low bytes.
// - 64-bit write replaces the whole register.
// - 32-bit write zero-extends into upper half.
// - Byte and word writes keep upper bits.
// - Upper halves need not survive leaving 64-bit.
// - Six 16-bit selectors: code, stack, four data.
// - Fetch address is code selector plus pointer.
// - Code selector changes only on control transfers.
// - Stack selector loadable; stack operations use it.
// - Code, stack, first two data bases forced zero.
// - Third and fourth data keep their real base.
// - Segment loads still run legacy validity checks.
// - No limit checks at all in 64-bit mode.
// - Low 16 bits of first eight are word views.

`timescale 1ns/100ps
`default_nettype none

module grf_top (
	input wire logic REF_CLK, // Core clock, 20 MHz
	input wire logic ARST_N, // Async reset, active low
	input wire grf_pkg::grf_mode_t MODE, // Current operating mode
	input wire logic EXT_PREFIX, // Instruction has extension prefix
	input wire logic [3:0] RD_A_SEL, // Read port A register selector
	input wire grf_pkg::grf_size_t RD_A_SIZE, // Read port A size
	input wire logic [3:0] RD_B_SEL, // Read port B register selector
	input wire grf_pkg::grf_size_t RD_B_SIZE, // Read port B size
	output logic [63:0] RD_A_DATA, // Read port A view, zero-extended
	output logic RD_A_ERR, // Read port A operand illegal
	output logic [63:0] RD_B_DATA, // Read port B view, zero-extended
	output logic RD_B_ERR, // Read port B operand illegal
	input wire logic WR_EN, // Write request
	input wire logic [3:0] WR_SEL, // Write register selector
	input wire grf_pkg::grf_size_t WR_SIZE, // Write size
	input wire logic [63:0] WR_DATA, // Write result, low aligned
	output logic WR_ERR, // Last write refused
	input wire logic SEG_LD_EN, // Segment load request
	input wire grf_pkg::grf_seg_t SEG_LD_SEG, // Segment to load
	input wire grf_pkg::grf_load_t SEG_LD_KIND, // Load origin
	input wire logic [15:0] SEG_LD_VALUE, // Selector to load
	input wire logic [63:0] SEG_LD_BASE, // Base from descriptor
	output logic SEG_LD_ERR, // Last segment load refused
	input wire logic IP_LD_EN, // Instruction pointer load
	input wire logic [63:0] IP_LD_VALUE, // Next instruction offset
	output logic [15:0] FETCH_SELECTOR, // Code selector for fetch
	output logic [63:0] FETCH_OFFSET, // Offset for fetch
	input wire grf_pkg::grf_seg_t ACC_SEG, // Segment of a data access
	input wire logic STACK_OP, // Access is a stack operation
	output logic [15:0] ACC_SELECTOR, // Selector of the access
	output logic [63:0] ACC_BASE, // Base to add for the access
	output logic LIMIT_CHECK_EN, // Segment limit checks active
	output logic VEC_ADDED_LOST // Pulse: added vector regs undefined
);
	import grf_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Extracts a view; byte reads may come from bits 15:8
	function automatic logic [63:0] grf_view(input logic [63:0] d,
		input grf_size_t size, input logic hi);
		case (size)
			GRF_SZ8: grf_view = {56'h0, hi ? d[15:8] : d[7:0]};
			GRF_SZ16: grf_view = {48'h0, d[15:0]};
			GRF_SZ32: grf_view = {32'h0, d[31:0]};
			default: grf_view = d;
		endcase
	endfunction : grf_view

	// Resolves selector and size into register and high-byte flag
	function automatic logic [4:0] grf_target(input logic [3:0] sel,
		input grf_size_t size, input logic pfx);
		if (size == GRF_SZ8) begin
			grf_target = grf_byte_map(sel, pfx);
		end else begin
			grf_target = {1'b0, sel};
		end
	endfunction : grf_target

	grf_gpr_if gpr ();

	grf_gpr_mem u_mem (
		.clk(REF_CLK),
		.arst_n(ARST_N),
		.bus(gpr)
	);

	// ----------------------------------------------------------------
	// Mode tracking
	// ----------------------------------------------------------------
	grf_mode_t mode_q;
	logic legacy_seen_q;
	logic legacy_seen_d;
	logic lost_q;
	logic lost_d;
	logic clr_added;

	// A trip that reached legacy or real mode wipes the added registers
	// on return; a compat-only trip keeps them. Upper halves are kept
	// on leaving 64-bit mode; they are only allowed, not required, to go.
	always_comb begin
		legacy_seen_d = legacy_seen_q;
		clr_added = 1'b0;
		if (MODE == GRF_MODE_LEGACY) begin
			legacy_seen_d = 1'b1;
		end else if (MODE == GRF_MODE_64 && mode_q != GRF_MODE_64) begin
			clr_added = legacy_seen_q;
			legacy_seen_d = 1'b0;
		end
		lost_d = clr_added;
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode_q <= GRF_MODE_64;
			legacy_seen_q <= 1'b0;
			lost_q <= 1'b0;
		end else begin
			mode_q <= MODE;
			legacy_seen_q <= legacy_seen_d;
			lost_q <= lost_d;
		end
	end

	assign VEC_ADDED_LOST = lost_q;
	assign gpr.clr_added = clr_added;

	// ----------------------------------------------------------------
	// Write path
	// ----------------------------------------------------------------
	logic [4:0] wr_tgt;
	logic wr_ok;
	logic wr_err_q;
	logic wr_err_d;

	// Size picks lanes; the prefix is shared by every operand of the
	// instruction, so high bytes and new bytes can never meet
	always_comb begin
		wr_tgt = grf_target(WR_SEL, WR_SIZE, EXT_PREFIX);
		wr_ok = grf_op_legal(WR_SEL, WR_SIZE, EXT_PREFIX);
		gpr.we = WR_EN && wr_ok;
		gpr.wsel = wr_tgt[3:0];
		gpr.wclr_hi = 1'b0;
		gpr.wdata = WR_DATA;
		case (WR_SIZE)
			GRF_SZ8: begin
				gpr.wbe = wr_tgt[4] ? GRF_BE_B1 : GRF_BE_B0;
				gpr.wdata = {8{WR_DATA[7:0]}};
			end
			GRF_SZ16: begin
				gpr.wbe = GRF_BE_W;
			end
			GRF_SZ32: begin
				gpr.wbe = GRF_BE_D;
				gpr.wclr_hi = 1'b1;
			end
			default: begin
				gpr.wbe = GRF_BE_Q;
			end
		endcase
		wr_err_d = wr_err_q;
		if (WR_EN) begin
			wr_err_d = !wr_ok;
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_err_q <= 1'b0;
		end else begin
			wr_err_q <= wr_err_d;
		end
	end

	assign WR_ERR = wr_err_q;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Stage one rides beside the storage read; stage two shapes the view
	logic [4:0] ra_tgt;
	logic [4:0] rb_tgt;
	logic [1:0] hi_q;
	logic [1:0] hi_d;
	logic [1:0] bad_q;
	logic [1:0] bad_d;
	grf_size_t sza_q;
	grf_size_t szb_q;
	logic [63:0] rda_q;
	logic [63:0] rda_d;
	logic [63:0] rdb_q;
	logic [63:0] rdb_d;
	logic [1:0] err_q;
	logic [1:0] err_d;

	always_comb begin
		ra_tgt = grf_target(RD_A_SEL, RD_A_SIZE, EXT_PREFIX);
		rb_tgt = grf_target(RD_B_SEL, RD_B_SIZE, EXT_PREFIX);
		gpr.ra_sel = ra_tgt[3:0];
		gpr.rb_sel = rb_tgt[3:0];
		hi_d = {rb_tgt[4], ra_tgt[4]};
		bad_d[0] = !grf_op_legal(RD_A_SEL, RD_A_SIZE, EXT_PREFIX);
		bad_d[1] = !grf_op_legal(RD_B_SEL, RD_B_SIZE, EXT_PREFIX);
		// Illegal operands read as zero so nothing stale leaks out
		rda_d = bad_q[0] ? 64'h0 : grf_view(gpr.ra_data, sza_q, hi_q[0]);
		rdb_d = bad_q[1] ? 64'h0 : grf_view(gpr.rb_data, szb_q, hi_q[1]);
		err_d = bad_q;
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			hi_q <= 2'b00;
			bad_q <= 2'b00;
			sza_q <= GRF_SZ32;
			szb_q <= GRF_SZ32;
			rda_q <= GRF_GPR_RST;
			rdb_q <= GRF_GPR_RST;
			err_q <= 2'b00;
		end else begin
			hi_q <= hi_d;
			bad_q <= bad_d;
			sza_q <= RD_A_SIZE;
			szb_q <= RD_B_SIZE;
			rda_q <= rda_d;
			rdb_q <= rdb_d;
			err_q <= err_d;
		end
	end

	assign RD_A_DATA = rda_q;
	assign RD_B_DATA = rdb_q;
	assign RD_A_ERR = err_q[0];
	assign RD_B_ERR = err_q[1];

	// ----------------------------------------------------------------
	// Segment registers
	// ----------------------------------------------------------------
	logic seg_bad;
	logic [15:0] seg_sel [GRF_NSEG];
	logic [63:0] seg_base [GRF_NSEG];

	grf_seg_file u_seg (
		.clk(REF_CLK),
		.arst_n(ARST_N),
		.ld_en(SEG_LD_EN),
		.ld_seg(SEG_LD_SEG),
		.ld_kind(SEG_LD_KIND),
		.ld_value(SEG_LD_VALUE),
		.ld_base(SEG_LD_BASE),
		.ld_bad(seg_bad),
		.sel_o(seg_sel),
		.base_o(seg_base)
	);

	grf_seg_t acc_seg;
	logic seg_err_q;
	logic seg_err_d;
	logic [15:0] acc_sel_q;
	logic [15:0] acc_sel_d;
	logic [63:0] acc_base_q;
	logic [63:0] acc_base_d;
	logic lim_q;
	logic lim_d;

	// Flat model in 64-bit mode, except the two base-carrying segments
	always_comb begin
		acc_seg = STACK_OP ? GRF_SEG_STACK : ACC_SEG;
		acc_sel_d = seg_sel[acc_seg];
		acc_base_d = seg_base[acc_seg];
		if (MODE == GRF_MODE_64) begin
			if (acc_seg == GRF_SEG_THIRD_DATA ||
				acc_seg == GRF_SEG_FOURTH_DATA) begin
				acc_base_d = seg_base[acc_seg];
			end else begin
				acc_base_d = 64'h0;
			end
		end
		lim_d = MODE != GRF_MODE_64;
		seg_err_d = seg_err_q;
		if (SEG_LD_EN) begin
			seg_err_d = seg_bad;
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			acc_sel_q <= GRF_SEG_RST;
			acc_base_q <= GRF_BASE_RST;
			lim_q <= 1'b0;
			seg_err_q <= 1'b0;
		end else begin
			acc_sel_q <= acc_sel_d;
			acc_base_q <= acc_base_d;
			lim_q <= lim_d;
			seg_err_q <= seg_err_d;
		end
	end

	assign ACC_SELECTOR = acc_sel_q;
	assign ACC_BASE = acc_base_q;
	assign LIMIT_CHECK_EN = lim_q;
	assign SEG_LD_ERR = seg_err_q;

	// ----------------------------------------------------------------
	// Instruction fetch address
	// ----------------------------------------------------------------
	logic [63:0] ip_q;
	logic [63:0] ip_d;
	logic [15:0] fsel_q;
	logic [15:0] fsel_d;

	// Selector and offset are registered; the selector comes from the stored code selector, one edge behind an offset loaded in the same cycle
	always_comb begin
		ip_d = IP_LD_EN ? IP_LD_VALUE : ip_q;
		fsel_d = seg_sel[GRF_SEG_CODE];
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ip_q <= GRF_IP_RST;
			fsel_q <= GRF_SEG_RST;
		end else begin
			ip_q <= ip_d;
			fsel_q <= fsel_d;
		end
	end

	assign FETCH_SELECTOR = fsel_q;
	assign FETCH_OFFSET = ip_q;
endmodule : grf_top

`default_nettype wire

// ---- testbench/grf_assertions.sv ----
// Purpose: Port checks for the register file.
// Assumes: One clock; reset is asynchronous, active low.
// Notes: Reads answer two edges late, the rest one.
`timescale 1ns/100ps
`default_nettype none
module grf_assertions (
	input wire logic REF_CLK, // Core clock
	input wire logic ARST_N, // Reset, active low
	input wire grf_pkg::grf_mode_t MODE, // Operating mode
	input wire logic EXT_PREFIX, // Extension prefix
	input wire logic [3:0] RD_A_SEL, // Read selector
	input wire grf_pkg::grf_size_t RD_A_SIZE, // Read size
	input wire logic [63:0] RD_A_DATA, // Read view
	input wire logic RD_A_ERR, // Read refused
	input wire logic WR_EN, // Write strobe
	input wire logic [3:0] WR_SEL, // Write target
	input wire grf_pkg::grf_size_t WR_SIZE, // Write size
	input wire logic WR_ERR, // Write refused
	input wire logic SEG_LD_EN, // Segment load
	input wire grf_pkg::grf_seg_t SEG_LD_SEG, // Segment loaded
	input wire grf_pkg::grf_load_t SEG_LD_KIND, // Load origin
	input wire logic [15:0] SEG_LD_VALUE, // Selector loaded
	input wire logic SEG_LD_ERR, // Load refused
	input wire logic IP_LD_EN, // Pointer load
	input wire logic [63:0] IP_LD_VALUE, // Pointer value
	input wire logic [63:0] FETCH_OFFSET, // Fetch offset
	input wire grf_pkg::grf_seg_t ACC_SEG, // Queried segment
	input wire logic STACK_OP, // Stack access
	input wire logic [63:0] ACC_BASE, // Base answer
	input wire logic LIMIT_CHECK_EN, // Limit checks on
	input wire logic VEC_ADDED_LOST // Added registers lost
);
	import grf_pkg::*;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	// A refused read also blanks its data
	sequence s_bad_rd;
		!EXT_PREFIX && (RD_A_SIZE == GRF_SZ64 || RD_A_SEL[3]);
	endsequence
	sequence s_err_ans;
		##2 (RD_A_ERR && RD_A_DATA == 64'h0);
	endsequence
	rd_refuse_a: assert property (s_bad_rd |-> s_err_ans)
		else $error("illegal read not refused");
	rd_ok_a: assert property (EXT_PREFIX |-> ##2 !RD_A_ERR)
		else $error("prefixed read refused");
	byte_view_a: assert property (RD_A_SIZE == GRF_SZ8
		|-> ##2 RD_A_DATA[63:8] == 56'h0) else $error("byte view wide");
	word_view_a: assert property (RD_A_SIZE == GRF_SZ16
		|-> ##2 RD_A_DATA[63:16] == 48'h0) else $error("word view wide");
	wr_refuse_a: assert property (WR_EN && !EXT_PREFIX
		&& (WR_SEL[3] || WR_SIZE == GRF_SZ64) |=> WR_ERR)
		else $error("illegal write not refused");
	wr_ok_a: assert property (WR_EN && EXT_PREFIX |=> !WR_ERR)
		else $error("prefixed write refused");
	code_load_a: assert property (SEG_LD_EN && SEG_LD_KIND ==
		GRF_LD_EXPLICIT && SEG_LD_SEG == GRF_SEG_CODE |=> SEG_LD_ERR)
		else $error("explicit code load accepted");
	stack_null_a: assert property (SEG_LD_EN && SEG_LD_SEG ==
		GRF_SEG_STACK && SEG_LD_VALUE[15:2] == 14'h0 |=> SEG_LD_ERR)
		else $error("null stack selector accepted");
	flat_base_a: assert property (MODE == GRF_MODE_64 &&
		(STACK_OP || ACC_SEG < GRF_SEG_THIRD_DATA) |=> ACC_BASE == 64'h0)
		else $error("flat segment base not zero");
	limit_off_a: assert property (MODE == GRF_MODE_64
		|=> !LIMIT_CHECK_EN) else $error("limit check on in 64-bit");
	fetch_ip_a: assert property (IP_LD_EN
		|=> FETCH_OFFSET == $past(IP_LD_VALUE))
		else $error("fetch offset not loaded");
	lost_pulse_a: assert property ($rose(VEC_ADDED_LOST)
		|=> !VEC_ADDED_LOST) else $error("lost flag not a pulse");
endmodule : grf_assertions
bind grf_top grf_assertions u_grf_assertions (.*);
`default_nettype wire

// ---- testbench/grf_decode_model.sv ----
// Purpose: Decode stage model issuing operand reads and writes.
// Assumes: Requests change 1 ns after a rising edge.
// Notes: Write strobe stays up across back-to-back writes.
`timescale 1ns/100ps
`default_nettype none
module grf_decode_model (
	input wire logic REF_CLK, // Core clock
	output logic EXT_PREFIX, // Prefix of current instruction
	output logic WR_EN, // Write strobe
	output logic [3:0] WR_SEL, // Write target
	output grf_pkg::grf_size_t WR_SIZE, // Write size
	output logic [63:0] WR_DATA, // Result
	output logic [3:0] RD_A_SEL, // Read target
	output grf_pkg::grf_size_t RD_A_SIZE // Read size
);
	import grf_pkg::*;
	// ----------------------------------------
	// Idle state and issue tasks
	// ----------------------------------------
	initial begin
		EXT_PREFIX = 1'b0;
		WR_EN = 1'b0;
		WR_SEL = 4'h0;
		WR_SIZE = GRF_SZ32;
		WR_DATA = 64'h0;
		RD_A_SEL = 4'h0;
		RD_A_SIZE = GRF_SZ32;
	end
	// One prefix flag covers the whole instruction
	task automatic wr(input logic p, input logic [3:0] s,
		input grf_size_t z, input logic [63:0] d);
		EXT_PREFIX = p;
		WR_SEL = s;
		WR_SIZE = z;
		WR_DATA = d;
		WR_EN = 1'b1;
		@(posedge REF_CLK);
		#1;
	endtask : wr
	// Flip idle write data so stale values show
	task automatic rd(input logic p, input logic [3:0] s,
		input grf_size_t z);
		WR_EN = 1'b0;
		WR_DATA = ~WR_DATA;
		EXT_PREFIX = p;
		RD_A_SEL = s;
		RD_A_SIZE = z;
		repeat (3) @(posedge REF_CLK);
		#1;
	endtask : rd
endmodule : grf_decode_model
`default_nettype wire

// ---- testbench/grf_top_tb.sv ----
// Purpose: Self-checking bench for the register file top.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Added registers read zero after a legacy trip.
`timescale 1ns/100ps
`default_nettype none
module grf_top_tb;
	import grf_pkg::*;
	logic REF_CLK, ARST_N, EXT_PREFIX, WR_EN, RD_A_ERR, RD_B_ERR, WR_ERR;
	logic SEG_LD_EN, SEG_LD_ERR, IP_LD_EN, STACK_OP, LIMIT_CHECK_EN;
	logic VEC_ADDED_LOST;
	logic [3:0] RD_A_SEL, RD_B_SEL, WR_SEL;
	logic [15:0] SEG_LD_VALUE, FETCH_SELECTOR, ACC_SELECTOR;
	logic [63:0] RD_A_DATA, RD_B_DATA, WR_DATA, SEG_LD_BASE, IP_LD_VALUE;
	logic [63:0] FETCH_OFFSET, ACC_BASE;
	grf_mode_t MODE;
	grf_size_t RD_A_SIZE, RD_B_SIZE, WR_SIZE;
	grf_seg_t SEG_LD_SEG, ACC_SEG;
	grf_load_t SEG_LD_KIND;
	int fail_count = 0;
	int n_tests = 0;
	// ----------------------------------------
	// Instances, clock, watchdog
	// ----------------------------------------
	grf_top u_grf_top (.*);
	grf_decode_model u_grf_decode_model (.*);
	initial begin
		REF_CLK = 1'b0;
		forever #25 REF_CLK = ~REF_CLK;
	end
	// Run takes under a hundred cycles
	initial begin
		repeat (3000) @(posedge REF_CLK);
		fail_count++;
		report_and_stop();
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic step;
		@(posedge REF_CLK);
		#1;
	endtask : step
	task automatic rdc(input logic p, input logic [3:0] s,
		input grf_size_t z, input logic [63:0] e, input logic er);
		u_grf_decode_model.rd(p, s, z);
		chk("read data", RD_A_DATA, e);
		chk("read error", {63'h0, RD_A_ERR}, {63'h0, er});
	endtask : rdc
	task automatic wrc(input logic p, input logic [3:0] s,
		input grf_size_t z, input logic [63:0] d, input logic er);
		u_grf_decode_model.wr(p, s, z, d);
		chk("write error", {63'h0, WR_ERR}, {63'h0, er});
	endtask : wrc
	task automatic segc(input grf_seg_t g, input grf_load_t k,
		input logic [15:0] v, input logic [63:0] b, input logic er);
		SEG_LD_SEG = g;
		SEG_LD_KIND = k;
		SEG_LD_VALUE = v;
		SEG_LD_BASE = b;
		SEG_LD_EN = 1'b1;
		step();
		chk("load error", {63'h0, SEG_LD_ERR}, {63'h0, er});
	endtask : segc
	task automatic accc(input grf_seg_t g, input logic stk,
		input logic [15:0] es, input logic [63:0] eb);
		SEG_LD_EN = 1'b0;
		ACC_SEG = g;
		STACK_OP = stk;
		step();
		IP_LD_EN = 1'b0;
		chk("access selector", {48'h0, ACC_SELECTOR}, {48'h0, es});
		chk("access base", ACC_BASE, eb);
	endtask : accc
	task automatic pulses(input logic [63:0] e);
		logic [63:0] n = 64'h0;
		repeat (4) begin
			step();
			n = n + {63'h0, VEC_ADDED_LOST};
		end
		chk("lost pulses", n, e);
	endtask : pulses
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_views;
		wrc(1'b1, 4'h0, GRF_SZ64, 64'h1122334455667788, 1'b0);
		wrc(1'b0, 4'h4, GRF_SZ8, 64'hab, 1'b0);
		wrc(1'b1, 4'h4, GRF_SZ8, 64'hcd, 1'b0);
		wrc(1'b1, 4'h8, GRF_SZ8, 64'h5a, 1'b0);
		rdc(1'b1, 4'h0, GRF_SZ64, 64'h112233445566ab88, 1'b0);
		rdc(1'b0, 4'h4, GRF_SZ8, 64'hab, 1'b0);
		rdc(1'b0, 4'h4, GRF_SZ16, 64'hcd, 1'b0);
		RD_B_SEL = 4'h8;
		rdc(1'b1, 4'h4, GRF_SZ8, 64'hcd, 1'b0);
		chk("port b data", RD_B_DATA, 64'h5a);
		chk("port b error", {63'h0, RD_B_ERR}, 64'h0);
	endtask : t_views
	task automatic t_sizes;
		wrc(1'b1, 4'h9, GRF_SZ64, 64'hffffffffffffffff, 1'b0);
		wrc(1'b1, 4'h9, GRF_SZ16, 64'h1234, 1'b0);
		rdc(1'b1, 4'h9, GRF_SZ64, 64'hffffffffffff1234, 1'b0);
		wrc(1'b1, 4'h9, GRF_SZ32, 64'hffffffff9abcdef0, 1'b0);
		rdc(1'b1, 4'h9, GRF_SZ64, 64'h9abcdef0, 1'b0);
		wrc(1'b0, 4'h9, GRF_SZ32, 64'h1, 1'b1);
		wrc(1'b0, 4'h1, GRF_SZ64, 64'h1, 1'b1);
		rdc(1'b1, 4'h9, GRF_SZ32, 64'h9abcdef0, 1'b0);
		rdc(1'b0, 4'h1, GRF_SZ64, 64'h0, 1'b1);
		rdc(1'b0, 4'h9, GRF_SZ8, 64'h0, 1'b1);
		rdc(1'b1, 4'h1, GRF_SZ64, 64'h0, 1'b0);
	endtask : t_sizes
	task automatic t_seg;
		segc(GRF_SEG_CODE, GRF_LD_TRANSFER, 16'h18, 64'h1000, 1'b0);
		segc(GRF_SEG_CODE, GRF_LD_EXPLICIT, 16'h10, 64'h0, 1'b1);
		segc(GRF_SEG_STACK, GRF_LD_EXPLICIT, 16'h3, 64'h0, 1'b1);
		segc(GRF_SEG_STACK, GRF_LD_EXPLICIT, 16'h20, 64'h2000, 1'b0);
		segc(GRF_SEG_THIRD_DATA, GRF_LD_EXPLICIT, 16'h28, 64'h3000, 1'b0);
		segc(GRF_SEG_FOURTH_DATA, GRF_LD_EXPLICIT, 16'h30, 64'h4000, 1'b0);
		segc(GRF_SEG_FIRST_DATA, GRF_LD_EXPLICIT, 16'h38, 64'h5000, 1'b0);
		segc(GRF_SEG_EXTRA_DATA, GRF_LD_EXPLICIT, 16'h40, 64'h6000, 1'b0);
		IP_LD_VALUE = 64'h00007fff00001234;
		IP_LD_EN = 1'b1;
		accc(GRF_SEG_CODE, 1'b0, 16'h18, 64'h0);
		chk("fetch selector", {48'h0, FETCH_SELECTOR}, 64'h18);
		chk("fetch offset", FETCH_OFFSET, 64'h00007fff00001234);
		accc(GRF_SEG_FIRST_DATA, 1'b1, 16'h20, 64'h0);
		accc(GRF_SEG_THIRD_DATA, 1'b0, 16'h28, 64'h3000);
		accc(GRF_SEG_FOURTH_DATA, 1'b0, 16'h30, 64'h4000);
		accc(GRF_SEG_EXTRA_DATA, 1'b0, 16'h40, 64'h0);
		MODE = GRF_MODE_COMPAT;
		accc(GRF_SEG_FIRST_DATA, 1'b0, 16'h38, 64'h5000);
		chk("limit in compat", {63'h0, LIMIT_CHECK_EN}, 64'h1);
		MODE = GRF_MODE_64;
		accc(GRF_SEG_STACK, 1'b0, 16'h20, 64'h0);
		chk("limit in 64", {63'h0, LIMIT_CHECK_EN}, 64'h0);
	endtask : t_seg
	task automatic t_mode;
		wrc(1'b1, 4'hc, GRF_SZ64, 64'h0123456789abcdef, 1'b0);
		rdc(1'b1, 4'hc, GRF_SZ64, 64'h0123456789abcdef, 1'b0);
		MODE = GRF_MODE_COMPAT;
		repeat (2) step();
		MODE = GRF_MODE_64;
		pulses(64'h0);
		rdc(1'b1, 4'hc, GRF_SZ64, 64'h0123456789abcdef, 1'b0);
		MODE = GRF_MODE_COMPAT;
		step();
		MODE = GRF_MODE_LEGACY;
		step();
		MODE = GRF_MODE_COMPAT;
		step();
		MODE = GRF_MODE_64;
		pulses(64'h1);
		rdc(1'b1, 4'hc, GRF_SZ64, 64'h0, 1'b0);
	endtask : t_mode
	// ----------------------------------------
	// Main sequence and verdict
	// ----------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		ARST_N = 1'b0;
		MODE = GRF_MODE_64;
		RD_B_SEL = 4'h0;
		RD_B_SIZE = GRF_SZ8;
		SEG_LD_EN = 1'b0;
		SEG_LD_SEG = GRF_SEG_CODE;
		SEG_LD_KIND = GRF_LD_EXPLICIT;
		SEG_LD_VALUE = 16'h0;
		SEG_LD_BASE = 64'h0;
		IP_LD_EN = 1'b0;
		IP_LD_VALUE = 64'h0;
		ACC_SEG = GRF_SEG_CODE;
		STACK_OP = 1'b0;
		repeat (12) @(posedge REF_CLK);
		#1;
		ARST_N = 1'b1;
		t_views();
		t_sizes();
		t_seg();
		t_mode();
		report_and_stop();
	end
endmodule : grf_top_tb
`default_nettype wire
